// >>> common/axis_irq_pkg.sv
// types shared by the interrupt block
package axis_irq_pkg;
   typedef logic [1:0] axis_t;
   typedef logic [5:0] reg_addr_t;
   typedef logic [31:0] word_t;
endpackage : axis_irq_pkg

// >>> common/axis_irq_regs.svh
// register offsets, field positions and reset values for the interrupt block
`ifndef AXIS_IRQ_REGS_SVH
`define AXIS_IRQ_REGS_SVH
// register index per axis: address = {axis[1:0], index[3:0]}
`define REG_MAIN_STATUS 4'h0
`define REG_ERROR_CAUSE 4'h1
`define REG_EVENT_CAUSE 4'h2
`define REG_EVENT_ENABLE 4'h3
`define REG_ENV_ONE 4'h4
`define REG_ENV_TWO 4'h5
`define REG_ENV_FIVE 4'h6
`define REG_PREREG_MODE 4'h7
`define REG_COMMAND 4'h8
`define REG_BUFFER 4'h9
// command codes written to the command register
`define CMD_READ_ERROR 8'hF2
`define CMD_READ_EVENT 8'hF3
`define CMD_WRITE_ENABLE 8'hAC
// field positions
`define BIT_STOP_FLAG 2
`define BIT_ERROR_FLAG 4
`define BIT_EVENT_FLAG 5
`define BIT_OUT_MASK 29
`define BIT_STOP_ENABLE 27
`define BIT_ERROR_HOLD 22
`define BIT_EVENT_HOLD 23
`define BIT_STOP_MODE 7
`define BIT_ERROR_UNUSED 11
// widths
`define ERROR_BITS 18
`define EVENT_BITS 20
`define ENABLE_BITS 19
`define AXES 4
// reset values
`define RESET_WORD 32'h0000_0000
`endif

// >>> test/host_cpu_model.sv
// host processor model: register bus master of the interrupt block
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
   input wire logic clock,
   output axis_irq_pkg::reg_addr_t addr,
   output axis_irq_pkg::word_t writeData,
   output logic writeStrobe,
   output logic readStrobe,
   input wire axis_irq_pkg::word_t readData
);
   import axis_irq_pkg::*;
   initial begin
      addr = '0;
      writeData = '0;
      writeStrobe = 1'b0;
      readStrobe = 1'b0;
   end
   task automatic wr(input reg_addr_t a, input word_t d);
      @(posedge clock);
      addr <= a;
      writeData <= d;
      writeStrobe <= 1'b1;
      @(posedge clock);
      writeStrobe <= 1'b0;
   endtask : wr
   // answer lives one cycle only, so it is taken just after the read edge
   task automatic rd(input reg_addr_t a, output word_t d);
      @(posedge clock);
      addr <= a;
      readStrobe <= 1'b1;
      @(posedge clock);
      readStrobe <= 1'b0;
      #1 d = readData;
   endtask : rd
endmodule : host_cpu_model
`default_nettype wire

// >>> test/irq_checker.sv
// port-level assertions for the axis interrupt output block
`timescale 1ns/1ps
`default_nettype none
module irq_checker (
   input wire logic clock,
   input wire logic rst,
   input wire axis_irq_pkg::reg_addr_t addr,
   input wire axis_irq_pkg::word_t writeData,
   input wire logic writeStrobe,
   input wire logic readStrobe,
   input wire axis_irq_pkg::word_t readData,
   input wire logic [71:0] errorEvent,
   input wire logic [79:0] eventEvent,
   input wire logic [3:0] axisRunning,
   input wire logic [3:0] nextQueued,
   input wire logic irq_n
);
   import axis_irq_pkg::*;
   logic m;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // mask mirror; the mask register is shared by all axes
   always_ff @(posedge clock) begin
      if (rst) m <= 1'b0;
      else if (writeStrobe && addr[3:0] == 4'h4) m <= writeData[29];
   end
   AST_ERR_X: assert property (errorEvent[0] && !m && !writeStrobe |=> !irq_n)
      else $error("error cause left irq high");
   AST_MASK: assert property (m |-> irq_n)
      else $error("masked irq went low");
   AST_HOLD: assert property (!irq_n && !readStrobe && !writeStrobe |=> !irq_n)
      else $error("irq released without a clear");
   AST_ERR_FLAG: assert property (errorEvent[0] && !writeStrobe ##1 !writeStrobe ##1 readStrobe && addr == 6'h00 |=> readData[4])
      else $error("error summary flag missing");
   AST_CAUSE_MAP: assert property (readStrobe && addr[3:0] == 4'h1 |=> readData[11] == 1'b0 && readData[31:18] == '0)
      else $error("unused error cause bits set");
   AST_ERR_U: assert property (errorEvent[54] && !m && !writeStrobe |=> !irq_n)
      else $error("axis three error left irq high");
   AST_COPY: assert property (writeStrobe && addr == 6'h08 && writeData[7:0] == 8'hF2 ##2 readStrobe && addr == 6'h09 |=> readData[31:18] == '0)
      else $error("copied error cause too wide");
   AST_IDLE: assert property (!$past(readStrobe) |-> readData == '0)
      else $error("read data outside answer cycle");
   cover property (!irq_n && m == 1'b0);
   cover property ($fell(axisRunning[2]) && nextQueued[2]);
   cover property (eventEvent[38] && !irq_n);
endmodule : irq_checker
bind axis_interrupt_output irq_checker chk (.clock, .rst, .addr, .writeData,
   .writeStrobe, .readStrobe, .readData, .errorEvent, .eventEvent,
   .axisRunning, .nextQueued, .irq_n);
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench for the axis interrupt output block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import axis_irq_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   reg_addr_t addr;
   word_t writeData, readData, d;
   logic writeStrobe, readStrobe, irq_n;
   logic [71:0] errorEvent = '0;
   logic [79:0] eventEvent = '0;
   logic [3:0] axisRunning = 4'hF;
   logic [3:0] nextQueued = 4'h0;
   int error_cnt = 0;
   int comparisons = 0;
   int cyc = 0;
   initial begin
      forever #25 clock = ~clock;
   end
   host_cpu_model host (.clock, .addr, .writeData, .writeStrobe, .readStrobe,
      .readData);
   axis_interrupt_output uut (.clock, .rst, .addr, .writeData, .writeStrobe,
      .readStrobe, .readData, .errorEvent, .eventEvent, .axisRunning,
      .nextQueued, .irq_n);
   task automatic end_sim;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input string n, input word_t e, input word_t g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick
   task automatic ck_irq(input logic e);
      chk("irq_n", 32'(e), 32'(irq_n));
   endtask : ck_irq
   task automatic rc(input reg_addr_t a, input word_t m, input word_t e);
      host.rd(a, d);
      chk("readData", e, d & m);
   endtask : rc
   task automatic pulse(input logic [71:0] e, input logic [79:0] v);
      @(posedge clock);
      errorEvent <= e;
      eventEvent <= v;
      @(posedge clock);
      errorEvent <= '0;
      eventEvent <= '0;
      #1;
   endtask : pulse
   // the stopping axis is Z; q says whether next data waits in the prereg
   task automatic fall(input logic [3:0] q);
      @(posedge clock);
      axisRunning <= 4'hF;
      nextQueued <= q;
      @(posedge clock);
      axisRunning <= 4'hB;
      tick(3);
   endtask : fall
   always @(posedge clock) begin
      cyc++;
      if (cyc > 3000) begin
         error_cnt++;
         end_sim();
      end
   end
   initial begin
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      pulse(72'h1, '0);
      ck_irq(0);
      rc(6'h00, 32'h10, 32'h10);
      host.wr(6'h08, 32'hF2);
      rc(6'h09, 32'h3_FFFF, 32'h1);
      ck_irq(1);
      pulse({18'h3_FFFF, 54'h0}, '0);
      rc(6'h31, 32'hFFFF_FFFF, 32'h3_F7FF);
      host.wr(6'h38, 32'hF2);
      tick(0);
      ck_irq(1);
      pulse('0, 80'h10_0000);
      ck_irq(1);
      rc(6'h12, 32'h1, 32'h1);
      host.wr(6'h18, 32'hF3);
      host.wr(6'h19, 32'h2_0000);
      host.wr(6'h18, 32'hAC);
      pulse('0, 80'h40_0000_0000);
      ck_irq(0);
      rc(6'h10, 32'h20, 32'h20);
      host.wr(6'h18, 32'hF3);
      tick(0);
      ck_irq(1);
      host.wr(6'h05, 32'h800_0000);
      fall(4'h0);
      ck_irq(0);
      rc(6'h22, 32'hFFFF_FFFF, 32'h0);
      rc(6'h20, 32'h4, 32'h4);
      rc(6'h20, 32'h4, 32'h0);
      ck_irq(1);
      host.wr(6'h27, 32'h80);
      fall(4'h4);
      ck_irq(1);
      fall(4'h0);
      ck_irq(0);
      rc(6'h20, 32'h4, 32'h4);
      host.wr(6'h04, 32'h2000_0000);
      pulse(72'h1, '0);
      ck_irq(1);
      rc(6'h00, 32'h10, 32'h10);
      host.wr(6'h04, 32'h0);
      tick(0);
      ck_irq(0);
      host.wr(6'h06, 32'h40_0000);
      host.wr(6'h08, 32'hF2);
      tick(0);
      ck_irq(0);
      host.wr(6'h06, 32'h0);
      host.wr(6'h08, 32'hF2);
      tick(0);
      ck_irq(1);
      pulse(72'h4_0000, '0);
      ck_irq(0);
      for (int i = 0; i < 4; i++) begin
         host.rd({2'(i), 4'h0}, d);
         if (d[4]) begin
            host.wr({2'(i), 4'h8}, 32'hF2);
         end
      end
      for (int i = 0; i < 4; i++) begin
         rc({2'(i), 4'h0}, 32'h34, 32'h0);
      end
      ck_irq(1);
      pulse(72'h1, '0);
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      #1;
      ck_irq(1);
      rc(6'h05, 32'hFFFF_FFFF, 32'h0);
      rc(6'h00, 32'hFFFF_FFFF, 32'h0);
      end_sim();
   end
endmodule : tb_top
`default_nettype wire

// >>> verilog/axis_interrupt_output.sv
// interrupt gathering and output logic for four motion axes
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "axis_irq_regs.svh"
module axis_interrupt_output (
   input wire logic clock,
   input wire logic rst,
   input wire axis_irq_pkg::reg_addr_t addr,
   input wire axis_irq_pkg::word_t writeData,
   input wire logic writeStrobe,
   input wire logic readStrobe,
   output axis_irq_pkg::word_t readData,
   input wire logic [`AXES*`ERROR_BITS-1:0] errorEvent,
   input wire logic [`AXES*`EVENT_BITS-1:0] eventEvent,
   input wire logic [`AXES-1:0] axisRunning,
   input wire logic [`AXES-1:0] nextQueued,
   output logic irq_n
);
   import axis_irq_pkg::*;

   logic [31:0] envOne;
   logic [31:0] envTwo;
   logic [31:0] envFive;
   logic [`AXES-1:0] stopMode;
   logic [`AXES-1:0] wasRunning;
   logic [`AXES-1:0] axisPending;
   logic [`AXES-1:0] stopFlag;
   logic [`AXES-1:0][`ERROR_BITS-1:0] errorCause;
   logic [`AXES-1:0][`EVENT_BITS-1:0] eventCause;
   logic [`AXES-1:0][`ENABLE_BITS-1:0] eventEnable;
   logic [`AXES-1:0][31:0] dataBuffer;
   logic errorHold;
   logic eventHold;
   axis_t sel;
   logic [3:0] regIndex;
   logic [`AXES-1:0] stopSummary;
   logic [`AXES-1:0] errorSummary;
   logic [`AXES-1:0] eventSummary;
   logic anyPending;
   logic outMask;
   logic stopEnable;
   logic envOneWrite;
   logic envTwoWrite;
   logic envFiveWrite;
   word_t next_readData;

   assign sel = addr[5:4];
   assign regIndex = addr[3:0];
   assign errorHold = envFive[`BIT_ERROR_HOLD];
   assign eventHold = envFive[`BIT_EVENT_HOLD];
   assign stopEnable = envTwo[`BIT_STOP_ENABLE];
   assign outMask = envOne[`BIT_OUT_MASK];
   // the axis field is ignored for the shared environment registers
   assign envOneWrite = writeStrobe && regIndex == `REG_ENV_ONE;
   assign envTwoWrite = writeStrobe && regIndex == `REG_ENV_TWO;
   assign envFiveWrite = writeStrobe && regIndex == `REG_ENV_FIVE;

   function automatic logic hit(
         input logic strobe,
         input reg_addr_t a,
         input logic [1:0] ax,
         input logic [3:0] idx);
      hit = strobe && a[5:4] == ax && a[3:0] == idx;
   endfunction : hit

   function automatic logic cmdHit(
         input logic strobe,
         input reg_addr_t a,
         input logic [1:0] ax,
         input word_t d,
         input logic [7:0] code);
      cmdHit = hit(strobe, a, ax, `REG_COMMAND) && d[7:0] == code;
   endfunction : cmdHit

   // direction-input changes (causes 17 and 18) share enable 17
   // cause 19, the start input, takes enable 18
   function automatic logic [`EVENT_BITS-1:0] spreadEnable(
         input logic [`ENABLE_BITS-1:0] en);
      spreadEnable = {en[18], en[17], en[17:0]};
   endfunction : spreadEnable

   // environment registers are shared by all axes in this block
   always_ff @(posedge clock) begin
      if (rst) begin
         envOne <= `RESET_WORD;
      end else if (envOneWrite) begin
         envOne <= writeData;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         envTwo <= `RESET_WORD;
      end else if (envTwoWrite) begin
         envTwo <= writeData;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         envFive <= `RESET_WORD;
      end else if (envFiveWrite) begin
         envFive <= writeData;
      end
   end

   genvar a;
   // one slice of causes, enables and stop detection per axis
   generate
      for (a = 0; a < `AXES; a = a + 1) begin : g_axis
         logic readErr;
         logic readEvt;
         logic readStat;
         logic stopEdge;
         logic stopFall;
         logic stopBlocked;
         logic clearErr;
         logic clearEvt;
         logic clearStop;
         logic loadEnable;
         logic writeMode;
         logic writeBuffer;
         logic errorWants;
         logic eventWants;
         logic [`ERROR_BITS-1:0] errIn;
         logic [`EVENT_BITS-1:0] evtIn;

         assign readErr = cmdHit(writeStrobe, addr, 2'(a), writeData,
            `CMD_READ_ERROR);
         assign readEvt = cmdHit(writeStrobe, addr, 2'(a), writeData,
            `CMD_READ_EVENT);
         assign readStat = hit(readStrobe, addr, 2'(a), `REG_MAIN_STATUS);
         // operating to stopped, seen one edge after the pin falls
         assign stopFall = wasRunning[a] && !axisRunning[a];
         // mode bit suppresses only when next data is queued
         assign stopBlocked = stopMode[a] && nextQueued[a];
         assign stopEdge = stopFall && stopEnable && !stopBlocked;
         assign errIn = errorEvent[a*`ERROR_BITS +: `ERROR_BITS]
            & ~(`ERROR_BITS'(1) << `BIT_ERROR_UNUSED);
         assign evtIn = eventEvent[a*`EVENT_BITS +: `EVENT_BITS];
         // hold bits turn the reads into plain reads with no side effect
         assign clearErr = readErr && !errorHold;
         assign clearEvt = readEvt && !eventHold;
         assign clearStop = readStat && !eventHold;
         assign loadEnable = cmdHit(writeStrobe, addr, 2'(a), writeData,
            `CMD_WRITE_ENABLE);
         assign writeMode = hit(writeStrobe, addr, 2'(a), `REG_PREREG_MODE);
         assign writeBuffer = hit(writeStrobe, addr, 2'(a), `REG_BUFFER);
         assign stopSummary[a] = stopFlag[a];
         assign errorSummary[a] = |errorCause[a];
         assign eventSummary[a] = |eventCause[a];

         // reset value 0 keeps a false stop edge away after reset
         always_ff @(posedge clock) begin
            if (rst) begin
               wasRunning[a] <= 1'b0;
            end else begin
               wasRunning[a] <= axisRunning[a];
            end
         end

         always_ff @(posedge clock) begin
            if (rst) begin
               stopMode[a] <= 1'b0;
            // only the stop mode bit of the pre-register lives here
            end else if (writeMode) begin
               stopMode[a] <= writeData[`BIT_STOP_MODE];
            end
         end

         // new causes win over a clear in the same cycle
         always_ff @(posedge clock) begin
            if (rst) begin
               errorCause[a] <= '0;
            // a cause arriving in the clear cycle is kept
            end else if (clearErr) begin
               errorCause[a] <= errIn;
            end else begin
               errorCause[a] <= errorCause[a] | errIn;
            end
         end

         always_ff @(posedge clock) begin
            if (rst) begin
               eventCause[a] <= '0;
            end else if (clearEvt) begin
               eventCause[a] <= evtIn;
            // a cause is recorded even while its enable is off
            end else begin
               eventCause[a] <= eventCause[a] | evtIn;
            end
         end

         always_ff @(posedge clock) begin
            if (rst) begin
               stopFlag[a] <= 1'b0;
            end else if (stopEdge) begin
               stopFlag[a] <= 1'b1;
            // a stop in the read cycle survives the clear
            end else if (clearStop) begin
               stopFlag[a] <= 1'b0;
            end
         end

         always_ff @(posedge clock) begin
            if (rst) begin
               eventEnable[a] <= '0;
            end else if (loadEnable) begin
               eventEnable[a] <= dataBuffer[a][`ENABLE_BITS-1:0];
            end
         end

         // read commands snapshot the cause before it is cleared
         always_ff @(posedge clock) begin
            if (rst) begin
               dataBuffer[a] <= `RESET_WORD;
            end else if (readErr) begin
               dataBuffer[a] <= 32'(errorCause[a]);
            end else if (readEvt) begin
               dataBuffer[a] <= 32'(eventCause[a]);
            end else if (writeBuffer) begin
               dataBuffer[a] <= writeData;
            end
         end

         assign errorWants = |errorCause[a];
         assign eventWants =
            |(eventCause[a] & spreadEnable(eventEnable[a]));
         assign axisPending[a] = errorWants || eventWants
            || stopFlag[a];
      end
   endgenerate

   // level output: stays low while unmasked and any axis holds an error cause, an enabled event cause or a stop flag
   assign anyPending = |axisPending;
   // combinational path so unmasking shows at once
   assign irq_n = !(anyPending && !outMask);

   function automatic word_t mainStatus(
         input logic stop,
         input logic err,
         input logic evt);
      mainStatus = `RESET_WORD;
      mainStatus[`BIT_STOP_FLAG] = stop;
      mainStatus[`BIT_ERROR_FLAG] = err;
      mainStatus[`BIT_EVENT_FLAG] = evt;
   endfunction : mainStatus

   // read mux; a read has no wait state and the answer is registered
   always_comb begin
      next_readData = `RESET_WORD;
      if (readStrobe) begin
         unique case (regIndex)
            `REG_MAIN_STATUS: next_readData = mainStatus(stopSummary[sel],
               errorSummary[sel], eventSummary[sel]);
            `REG_ERROR_CAUSE: next_readData = 32'(errorCause[sel]);
            `REG_EVENT_CAUSE: next_readData = 32'(eventCause[sel]);
            `REG_EVENT_ENABLE: next_readData = 32'(eventEnable[sel]);
            `REG_ENV_ONE: next_readData = envOne;
            `REG_ENV_TWO: next_readData = envTwo;
            `REG_ENV_FIVE: next_readData = envFive;
            `REG_PREREG_MODE: next_readData = mainStatus(1'b0, 1'b0, 1'b0)
               | (32'(stopMode[sel]) << `BIT_STOP_MODE);
            `REG_BUFFER: next_readData = dataBuffer[sel];
            default: next_readData = `RESET_WORD;
         endcase
      end
   end

   // answer stands for the one cycle after the read, zero otherwise
   always_ff @(posedge clock) begin
      if (rst) begin
         readData <= `RESET_WORD;
      end else begin
         readData <= next_readData;
      end
   end
endmodule : axis_interrupt_output
`default_nettype wire
